//--- rtl/dmx_pkg.sv
// package for the demux control registers and hot-plug timer
package dmx_pkg;
  // two-wire bus address: 1011, two straps, 1, r/w
  localparam logic [3:0] ADDR_FIXED_HI  = 4'hb;
  localparam logic       ADDR_FIXED_LO  = 1'b1;
  // register indexes (standby/routing has no printed index)
  localparam logic [7:0] IDX_STANDBY_ROUTING = 8'h00;
  localparam logic [7:0] IDX_RX_TUNING       = 8'h01;
  localparam logic [7:0] IDX_TX_SHAPING      = 8'h02;
  localparam logic [7:0] IDX_VENDOR_REV      = 8'h03;
  localparam logic [7:0] IDX_HOTPLUG         = 8'h04;
  localparam logic [7:0] RST_REG             = 8'h00;
  // arbitrary identity values, not a real vendor code
  localparam logic [3:0] VENDOR_CODE   = 4'ha;
  localparam logic [3:0] REVISION_CODE = 4'h2;
  // field positions
  localparam int STANDBY_BIT   = 7;
  localparam int SEL_HI        = 6;
  localparam int SWPULSE_BIT   = 2;
  localparam int PWRDN_BIT     = 1;
  localparam int IRQ_BIT       = 0;
  localparam int POL_BIT       = 7;
  localparam int DDC_BIT       = 6;
  localparam int NOPULSE_BIT   = 5;
  localparam int TX_RSVD_BIT   = 0;
  // port select codes
  localparam logic [1:0] SEL_PORT1 = 2'h0;
  localparam logic [1:0] SEL_OFF   = 2'h1;
  localparam logic [1:0] SEL_PORT2 = 2'h2;
  localparam logic [1:0] SEL_AUTO  = 2'h3;
  // timebase
  localparam int CLK_HZ        = 125_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYC      = CYC_PER_US * TICK_US;
  // times in ms, counted in 1 ms ticks
  localparam int IRQ_PULSE_MS_SHORT = 2;
  localparam int IRQ_PULSE_MS_LONG  = 4;
  localparam int UNPLUG_MS          = 125;
  localparam int SWITCH_MS_SLOW     = 256;
  localparam int SWITCH_MS_FAST     = 128;
  localparam int PWRDN_MS_SLOW      = 1024;
  localparam int PWRDN_MS_FAST      = 516;
  localparam int SCALE_NUM_MINUS    = 3;
  localparam int SCALE_NUM_PLUS     = 5;
  localparam int SCALE_DEN          = 4;
  localparam int TEST_MS            = 1;

  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_IDX, BUS_WDATA, BUS_RDATA} dmx_bus_st_t;

  typedef struct packed {
    logic       standby;
    logic [1:0] route;       // 00 none, 01 port1, 10 port2
    logic [2:0] equalizer_level;
    logic       tx_double_term;
    logic [2:0] tx_preemph;
    logic [1:0] tx_swing;
    logic       tx_fast_edge;
    logic       ddc_passive;
  } dmx_analog_t;
endpackage : dmx_pkg

//--- rtl/dmx_ctrl.sv
// two-wire register bank and hot-plug timing engine
`timescale 1ns/10ps
module dmx_ctrl
  import dmx_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // two-wire bus pins, enables low while driving
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        address_strap_high,
  input  wire logic        address_strap_low,
  // hot-plug
  input  wire logic        port1_hotplug_in,
  input  wire logic        port2_hotplug_in,
  input  wire logic        output_enable_low,
  output logic             source_hotplug_out,
  // analog controls
  output dmx_analog_t      analog,
  output logic             powered_down
);
  logic [7:0]  ctrl_r, rx_r, tx_r, hp_r;
  dmx_bus_st_t bus_st_r;
  logic        scl_d_r, sda_d_r, scl_dd_r, sda_dd_r;
  logic [7:0]  shift_r, idx_r, rdata_r;
  logic [3:0]  bit_cnt_r;
  logic        ack_phase_r;

  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] st);
    unique case (idx)
      IDX_STANDBY_ROUTING: reg_read = ctrl_r;
      IDX_RX_TUNING:       reg_read = rx_r;
      IDX_TX_SHAPING:      reg_read = tx_r;
      IDX_VENDOR_REV:      reg_read = {VENDOR_CODE, REVISION_CODE};
      IDX_HOTPLUG:         reg_read = {hp_r[7:4], st[3:0]};
      default:             reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // bus pins sampled twice to find edges
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      scl_dd_r <= 1'b1;
      sda_dd_r <= 1'b1;
    end else begin
      scl_d_r  <= scl_in;
      sda_d_r  <= sda_in;
      scl_dd_r <= scl_d_r;
      sda_dd_r <= sda_d_r;
    end
  end

  logic start_c, stop_c, rise_c, fall_c;
  assign start_c = scl_d_r && scl_dd_r && !sda_d_r && sda_dd_r;
  assign stop_c  = scl_d_r && scl_dd_r && sda_d_r && !sda_dd_r;
  assign rise_c  = scl_d_r && !scl_dd_r;
  assign fall_c  = !scl_d_r && scl_dd_r;

  logic [7:0] status_c, byte_c;
  assign status_c = {4'h0, port2_hotplug_in, 1'b0, port1_hotplug_in, 1'b0};
  assign byte_c   = {shift_r[6:0], sda_d_r};

  logic wr_en_c;
  assign wr_en_c = (bus_st_r == BUS_WDATA) && rise_c && !ack_phase_r && bit_cnt_r == 4'h7;

  // bus protocol engine
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_st_r    <= BUS_IDLE;
      shift_r     <= 8'h00;
      idx_r       <= 8'h00;
      rdata_r     <= 8'h00;
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      sda_out     <= 1'b1;
      sda_oe_n    <= 1'b1;
    end else if (start_c) begin
      bus_st_r    <= BUS_ADDR;
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (stop_c) begin
      bus_st_r <= BUS_IDLE;
      sda_oe_n <= 1'b1;
    end else if (bus_st_r != BUS_IDLE) begin
      if (rise_c && !ack_phase_r && bus_st_r != BUS_RDATA) begin
        shift_r   <= byte_c;
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (rise_c && ack_phase_r && bus_st_r == BUS_RDATA && sda_d_r) begin
        // master nack ends the read
        bus_st_r <= BUS_IDLE;
      end
      if (fall_c) begin
        if (ack_phase_r) begin
          ack_phase_r <= 1'b0;
          bit_cnt_r   <= 4'h0;
          sda_oe_n    <= 1'b1;
          if (bus_st_r == BUS_RDATA) begin
            sda_out  <= rdata_r[7];
            sda_oe_n <= rdata_r[7];
            rdata_r  <= {rdata_r[6:0], 1'b0};
            bit_cnt_r <= 4'h1;
          end
        end else if (bit_cnt_r == 4'h8) begin
          ack_phase_r <= 1'b1;
          unique case (bus_st_r)
            BUS_ADDR: begin
              if (shift_r[7:4] == ADDR_FIXED_HI && shift_r[3] == address_strap_high
                  && shift_r[2] == address_strap_low && shift_r[1] == ADDR_FIXED_LO) begin
                sda_out  <= 1'b0;
                sda_oe_n <= 1'b0;
                bus_st_r <= shift_r[0] ? BUS_RDATA : BUS_IDX;
                rdata_r  <= reg_read(idx_r, status_c);
              end else begin
                bus_st_r <= BUS_IDLE;
              end
            end
            BUS_IDX: begin
              idx_r    <= shift_r;
              bus_st_r <= BUS_WDATA;
              sda_out  <= 1'b0;
              sda_oe_n <= 1'b0;
            end
            BUS_WDATA: begin
              sda_out  <= 1'b0;
              sda_oe_n <= 1'b0;
              idx_r    <= idx_r + 8'h01;
            end
            BUS_RDATA: begin
              sda_oe_n <= 1'b1;
              idx_r    <= idx_r + 8'h01;
            end
            default: bus_st_r <= BUS_IDLE;
          endcase
        end else if (bus_st_r == BUS_RDATA) begin
          sda_out   <= rdata_r[7];
          sda_oe_n  <= rdata_r[7];
          rdata_r   <= {rdata_r[6:0], 1'b0};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
      if (bus_st_r == BUS_RDATA && ack_phase_r && fall_c)
        rdata_r <= reg_read(idx_r, status_c) << 1;
    end
  end

  // register writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= RST_REG;
      rx_r   <= RST_REG;
      tx_r   <= RST_REG;
      hp_r   <= RST_REG;
    end else if (wr_en_c) begin
      unique case (idx_r)
        IDX_STANDBY_ROUTING: ctrl_r <= byte_c;
        IDX_RX_TUNING:       rx_r   <= byte_c;
        IDX_TX_SHAPING:      tx_r   <= {byte_c[7:1], 1'b0};
        IDX_HOTPLUG:         hp_r   <= {byte_c[7:4], 4'h0};
        default: ;
      endcase
    end
  end

  // millisecond tick
  logic [16:0] tick_cnt_r;
  logic        tick_c;
  // test mode ticks every clock: ms counts become cycles, short enough to exercise
  assign tick_c = rx_r[4:3] == 2'h3 || tick_cnt_r == 17'(TICK_CYC - 1);
  always_ff @(posedge sys_clk) begin
    if (!resetn) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_c ? '0 : tick_cnt_r + 17'h1;
  end

  function automatic logic [11:0] scale_ms(input int ms, input logic [1:0] mode);
    unique case (mode)
      2'h0: scale_ms = 12'(ms);
      2'h1: scale_ms = 12'(ms * SCALE_NUM_MINUS / SCALE_DEN);
      2'h2: scale_ms = 12'(ms * SCALE_NUM_PLUS / SCALE_DEN);
      default: scale_ms = 12'(ms * TEST_MS);
    endcase
  endfunction : scale_ms

  logic [11:0] irq_ms_c, unplug_ms_c, switch_ms_c, pwrdn_ms_c;
  // irq limit, unplug delay, switch pulse, power-down delay
  assign irq_ms_c = scale_ms(rx_r[IRQ_BIT] ? IRQ_PULSE_MS_LONG : IRQ_PULSE_MS_SHORT, rx_r[4:3]);
  assign unplug_ms_c = scale_ms(UNPLUG_MS, rx_r[4:3]);
  assign switch_ms_c = scale_ms(rx_r[SWPULSE_BIT] ? SWITCH_MS_FAST : SWITCH_MS_SLOW, rx_r[4:3]);
  assign pwrdn_ms_c = scale_ms(rx_r[PWRDN_BIT] ? PWRDN_MS_FAST : PWRDN_MS_SLOW, rx_r[4:3]);

  // per-port debounced plug state: low shorter than the irq limit is irq only
  logic [1:0]  hp_in_c, plugged_r;
  logic [11:0] low_ms_r [2];
  assign hp_in_c = {port2_hotplug_in, port1_hotplug_in};
  for (genvar p = 0; p < 2; p++) begin : g_port
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        low_ms_r[p]  <= '0;
        plugged_r[p] <= 1'b0;
      end else if (hp_in_c[p]) begin
        low_ms_r[p]  <= '0;
        plugged_r[p] <= 1'b1;
      end else if (tick_c) begin
        if (low_ms_r[p] >= irq_ms_c) plugged_r[p] <= 1'b0;
        else low_ms_r[p] <= low_ms_r[p] + 12'h1;
      end
    end
  end

  logic [1:0] route_c;
  always_comb begin
    unique case (ctrl_r[SEL_HI -: 2])
      SEL_PORT1: route_c = 2'h1;
      SEL_OFF:   route_c = 2'h0;
      SEL_PORT2: route_c = 2'h2;
      default:   route_c = plugged_r[0] ? 2'h1 : (plugged_r[1] ? 2'h2 : 2'h0);
    endcase
  end

  logic [1:0]  route_r, plug_d_r;
  logic [11:0] pulse_ms_r, unplug_ms_r, pwr_ms_r;
  logic        sel_hp_c, src_level_r, pd_r;
  assign sel_hp_c = (route_r == 2'h1) ? plugged_r[0] : (route_r == 2'h2) ? plugged_r[1] : 1'b0;
  logic        pulse_load_c;
  assign pulse_load_c = (route_c != route_r
                         && !(hp_r[NOPULSE_BIT] && ctrl_r[SEL_HI -: 2] != SEL_AUTO))
                        || (plugged_r & ~plug_d_r) != 2'h0;

  // switch pulse, unplug propagation, power-down timers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      route_r     <= 2'h0;
      plug_d_r    <= 2'h0;
      pulse_ms_r  <= '0;
      unplug_ms_r <= '0;
      pwr_ms_r    <= '0;
      src_level_r <= 1'b0;
      pd_r        <= 1'b0;
    end else begin
      route_r  <= route_c;
      plug_d_r <= plugged_r;
      // low pulse on switch or plug-in
      if (pulse_load_c)
        pulse_ms_r <= switch_ms_c;
      else if (tick_c && pulse_ms_r != '0)
        pulse_ms_r <= pulse_ms_r - 12'h1;
      if (sel_hp_c) begin
        unplug_ms_r <= '0;
        src_level_r <= pulse_ms_r == '0;
      end else if (tick_c) begin
        if (unplug_ms_r >= unplug_ms_c) src_level_r <= 1'b0;
        else unplug_ms_r <= unplug_ms_r + 12'h1;
      end
      // no one-cycle high while a new pulse is being loaded
      if (pulse_ms_r != '0 || pulse_load_c) src_level_r <= 1'b0;
      if (plugged_r != 2'h0) begin
        pwr_ms_r <= '0;
        pd_r     <= 1'b0;
      end else if (tick_c) begin
        if (pwr_ms_r >= pwrdn_ms_c) pd_r <= 1'b1;
        else pwr_ms_r <= pwr_ms_r + 12'h1;
      end
    end
  end

  // outputs; polarity applies after timing
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      source_hotplug_out <= 1'b0;
      powered_down       <= 1'b1;
      analog             <= '0;
    end else begin
      source_hotplug_out <= src_level_r ^ hp_r[POL_BIT];
      powered_down <= ctrl_r[STANDBY_BIT] || output_enable_low || pd_r;
      analog.standby <= ctrl_r[STANDBY_BIT];
      analog.route   <= ctrl_r[STANDBY_BIT] ? 2'h0 : route_r;
      analog.equalizer_level <= rx_r[7:5];
      analog.tx_double_term <= tx_r[7];
      analog.tx_preemph     <= tx_r[6:4];
      analog.tx_swing       <= tx_r[3:2];
      analog.tx_fast_edge   <= tx_r[1];
      analog.ddc_passive    <= hp_r[DDC_BIT];
    end
  end

  AST_TX_RSVD_ZERO:
    assert property (@(posedge sys_clk) disable iff (!resetn) tx_r[TX_RSVD_BIT] == 1'b0)
      else $error("tx reserved bit set");
  AST_POL:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> source_hotplug_out == ($past(src_level_r) ^ $past(hp_r[POL_BIT])))
      else $error("polarity wrong");
  AST_PULSE_LOW:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      pulse_ms_r != '0 |=> src_level_r == 1'b0) else $error("pulse not low");
  AST_LOAD_LOW:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      pulse_load_c |=> src_level_r == 1'b0) else $error("high before switch pulse");
  AST_STANDBY:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl_r[STANDBY_BIT] |=> powered_down && analog.route == 2'h0)
      else $error("standby ignored");
  AST_HP_LOW_NIBBLE:
    assert property (@(posedge sys_clk) disable iff (!resetn) hp_r[3:0] == 4'h0)
      else $error("status bits stored");
  AST_IRQ_KEEP:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      plugged_r[0] && low_ms_r[0] < irq_ms_c |=> plugged_r[0]) else $error("irq dropped port");
  AST_PWR:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      plugged_r != 2'h0 |=> !pd_r) else $error("powered down while plugged");
  AST_AUTO_PRIO:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl_r[SEL_HI -: 2] == SEL_AUTO && plugged_r[0] |-> route_c == 2'h1)
      else $error("auto priority wrong");
endmodule : dmx_ctrl

//--- bench/dmx_bus_host.sv
// two-wire bus host model that programs the control registers
`timescale 1ns/10ps
module dmx_bus_host (
  // clock
  input  wire logic sys_clk,
  // bus, sda released high by the pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // phases of 8 clk keep well above the 4 clk minimum
  task automatic half;
    repeat (8) @(posedge sys_clk);
  endtask : half

  task automatic start;
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
  endtask : start

  task automatic stop;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask : stop

  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic v);
    half();
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    v = sda_line;
    scl <= 1'b0;
  endtask : bit_io

  // msb first, ninth bit is the acknowledge
  task automatic byte_io(input logic [7:0] b, output logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], v[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] data, output logic ack);
    logic [7:0] v;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    byte_io({addr, 1'b0}, v, a0);
    byte_io(idx, v, a1);
    byte_io(data, v, a2);
    stop();
    ack = a0 | a1 | a2;
  endtask : write_reg

  // index write, repeated start, one byte read then nack
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx,
                          output logic [7:0] data, output logic ack);
    logic [7:0] v;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       n;
    start();
    byte_io({addr, 1'b0}, v, a0);
    byte_io(idx, v, a1);
    start();
    byte_io({addr, 1'b1}, v, a2);
    byte_io(8'hff, data, n);
    stop();
    ack = a0 | a1 | a2;
  endtask : read_reg
endmodule : dmx_bus_host

//--- bench/demux_control_regs_hotplug_timer_bench.sv
// self-checking bench for the register bank over the two-wire bus
`timescale 1ns/10ps
module demux_control_regs_hotplug_timer_bench
  import dmx_pkg::*;
;
  localparam logic [6:0] ADDR  = {ADDR_FIXED_HI, 1'b1, 1'b0, ADDR_FIXED_LO};
  localparam int         LIMIT = 60000;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe_n;
  logic        oe_low  = 1'b0;
  logic        hp1     = 1'b1;
  logic        hp2     = 1'b1;
  logic        src_hp;
  logic        pdown;
  dmx_analog_t analog;
  wire logic   sda_line = sda_drv & (sda_oe_n | sda_out);
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  logic        ack;
  logic [1:0]  route_exp [4] = '{2'h1, 2'h0, 2'h2, 2'h1};

  always #4 sys_clk = ~sys_clk;

  dmx_ctrl dut (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .scl_in             (scl),
    .sda_in             (sda_line),
    .sda_out            (sda_out),
    .sda_oe_n           (sda_oe_n),
    .address_strap_high (1'b1),
    .address_strap_low  (1'b0),
    .port1_hotplug_in   (hp1),
    .port2_hotplug_in   (hp2),
    .output_enable_low  (oe_low),
    .source_hotplug_out (src_hp),
    .analog             (analog),
    .powered_down       (pdown)
  );

  dmx_bus_host host (
    .sys_clk  (sys_clk),
    .scl      (scl),
    .sda_drv  (sda_drv),
    .sda_line (sda_line)
  );

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    host.write_reg(ADDR, idx, data, ack);
    chk("write ack", 16'h0, 16'(ack));
    repeat (4) @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(ADDR, idx, d, ack);
    chk("read ack", 16'h0, 16'(ack));
    chk("read data", 16'(exp), 16'(d));
  endtask : rd

  // bounded run: a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("sda_oe_n", 16'h1, 16'(sda_oe_n));
    chk("source hotplug", 16'h0, 16'(src_hp));
    // select code 00 after power-up routes to port1
    chk("analog", 16'h0800, 16'(analog));
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, {VENDOR_CODE, REVISION_CODE});
    rd(8'h04, 8'h0a);
    // wrong strap bit in the address must not be acknowledged
    host.write_reg(ADDR ^ 7'h04, 8'h01, 8'hff, ack);
    chk("foreign addr nack", 16'h1, 16'(ack));
    rd(8'h01, 8'h00);
    wr(8'h01, 8'ha5);
    rd(8'h01, 8'ha5);
    chk("equalizer", 16'h5, 16'(analog.equalizer_level));
    wr(8'h02, 8'hbf);
    rd(8'h02, 8'hbe);
    chk("tx shaping", 16'h5f, 16'({analog.tx_double_term, analog.tx_preemph,
        analog.tx_swing, analog.tx_fast_edge}));
    wr(8'h03, 8'h00);
    rd(8'h03, {VENDOR_CODE, REVISION_CODE});
    rd(8'h07, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hfa);
    chk("ddc passive", 16'h1, 16'(analog.ddc_passive));
    // every select code, no-pulse bit set so routing is immediate
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, {1'b0, 2'(s), 5'h00});
      chk("route", 16'(route_exp[s]), 16'(analog.route));
    end
    wr(8'h00, 8'h80);
    chk("standby", 16'h1, 16'(analog.standby));
    wr(8'h00, 8'h00);
    chk("standby off", 16'h0, 16'(analog.standby));
    oe_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("powered down", 16'h1, 16'(pdown));
    oe_low <= 1'b0;
    hp2    <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 8'hf2);
    // test mode: timers count clocks, so nominal times fit in the run
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h18);
    repeat (300) @(posedge sys_clk);
    chk("source after pulse", 16'h1, 16'(src_hp));
    hp1 <= 1'b0;
    repeat (2) @(posedge sys_clk);
    hp1 <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("irq pulse kept", 16'h1, 16'(src_hp));
    hp1 <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk("unplug early", 16'h1, 16'(src_hp));
    repeat (60) @(posedge sys_clk);
    chk("unplug late", 16'h0, 16'(src_hp));
    repeat (800) @(posedge sys_clk);
    chk("power early", 16'h0, 16'(pdown));
    repeat (120) @(posedge sys_clk);
    chk("power late", 16'h1, 16'(pdown));
    hp1 <= 1'b1;
    repeat (240) @(posedge sys_clk);
    chk("plug pulse low", 16'h0, 16'(src_hp));
    chk("power up", 16'h0, 16'(pdown));
    repeat (30) @(posedge sys_clk);
    chk("plug pulse end", 16'h1, 16'(src_hp));
    wr(8'h04, 8'h80);
    chk("inverted source", 16'h0, 16'(src_hp));
    // the plug-in pulse of port2 ends during the next write
    hp2 <= 1'b1;
    wr(8'h04, 8'h20);
    wr(8'h00, 8'h40);
    chk("no switch pulse", 16'h1, 16'(src_hp));
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    chk("switch pulse", 16'h0, 16'(src_hp));
    stop_test();
  end
endmodule : demux_control_regs_hotplug_timer_bench
